// *** bench/ocp_far_side.sv ***
// far-side model: timer prescaler ticks, sync event sources and fault sources
`timescale 1ns/1ps
`default_nettype none
module ocp_far_side (
  input wire logic clk,
  input wire logic [4:0] ev_code,
  input wire logic ev_fire,
  input wire logic [2:0] fault_req,
  output logic timer1_prescale_tick,
  output logic timer3_prescale_tick,
  output logic [31:0] sync_events,
  output logic comparator_fault,
  output logic fault_pin_a,
  output logic fault_pin_b
);
  logic [2:0] t1_cnt;
  logic [2:0] t3_cnt;
  initial begin
    t1_cnt = 3'h0;
    t3_cnt = 3'h0;
    timer1_prescale_tick = 1'b0;
    timer3_prescale_tick = 1'b0;
    sync_events = 32'h0;
    {comparator_fault, fault_pin_b, fault_pin_a} = 3'h0;
  end
  // timer1 ticks every 3 clk, timer3 every 5, so the two rates differ
  always @(posedge clk) begin
    t1_cnt <= (t1_cnt == 3'h2) ? 3'h0 : t1_cnt + 3'h1;
    t3_cnt <= (t3_cnt == 3'h4) ? 3'h0 : t3_cnt + 3'h1;
    timer1_prescale_tick <= (t1_cnt == 3'h2);
    timer3_prescale_tick <= (t3_cnt == 3'h4);
    sync_events <= ev_fire ? (32'h1 << ev_code) : 32'h0;
    {comparator_fault, fault_pin_b, fault_pin_a} <= fault_req;
  end
endmodule
`default_nettype wire

// *** bench/ocp_unit_tb.sv ***
// self-checking bench for the compare/pwm channel
`timescale 1ns/1ps
`default_nettype none
module ocp_unit_tb
  import ocp_pkg::*;
;
  localparam logic [2:0] EXP_LV [5] = '{3'h6, 3'h1, 3'h6, 3'h2, 3'h2};
  localparam logic [2:0] CLK_TAB [4] = '{CLK_PERIPH, CLK_TMR1, CLK_TMR3, 3'h2};
  localparam int EXP_TK [4] = '{16, 21, 13, 0};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic t1_tick, t3_tick, cmp_flt, flt_a, flt_b, pin, oe, irq, sync_out;
  logic [31:0] sync_events;
  logic [4:0] ev_code = 5'h00;
  logic ev_fire = 1'b0;
  logic [2:0] fault_req = 3'h0;
  logic [15:0] rv, rv2;
  logic [2:0] e;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int irq_cnt = 0;
  int sync_cnt = 0;
  int t_rise, hi, pd, d, base;

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (sync_out === 1'b1) sync_cnt <= sync_cnt + 1;
  end

  ocp_unit #(.INSTR_DIV(4), .FAULT_LEVEL(1'b0)) i_dut (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer1_prescale_tick(t1_tick),
    .timer3_prescale_tick(t3_tick), .sync_events(sync_events),
    .comparator_fault(cmp_flt), .fault_pin_a(flt_a), .fault_pin_b(flt_b),
    .compare_output_pin(pin), .compare_output_oe(oe),
    .channel_interrupt_flag(irq), .sync_out(sync_out));
  ocp_far_side i_far (
    .clk(clk), .ev_code(ev_code), .ev_fire(ev_fire), .fault_req(fault_req),
    .timer1_prescale_tick(t1_tick), .timer3_prescale_tick(t3_tick),
    .sync_events(sync_events), .comparator_fault(cmp_flt),
    .fault_pin_a(flt_a), .fault_pin_b(flt_b));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rw, input logic [4:0] a, input logic [15:0] dat,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !rw;
    avs_write <= rw;
    avs_writedata <= {16'h0000, dat};
    avs_byteenable <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[15:0];
    chk(16'(n < 20), 16'h0001, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] dat);
    logic [15:0] q;
    bus(1'b1, a, dat, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp, input string w);
    bus(1'b0, a, 16'h0000, rv);
    chk(rv, exp, w);
  endtask
  task automatic lvl(input logic v);
    int n;
    n = 0;
    while (pin !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n < 400), 16'h0001, "pin level wait");
  endtask
  task automatic pulse();
    lvl(1'b0);
    lvl(1'b1);
    t_rise = cyc;
    lvl(1'b0);
    hi = cyc - t_rise;
    lvl(1'b1);
    pd = cyc - t_rise;
  endtask
  task automatic steady(input logic v, input string w);
    int bad;
    bad = 0;
    repeat (40) begin
      @(posedge clk);
      if (pin !== v) bad++;
    end
    chk(16'(bad), 16'h0000, w);
  endtask
  task automatic fire(input logic [4:0] c);
    @(posedge clk);
    ev_code <= c;
    ev_fire <= 1'b1;
    @(posedge clk);
    ev_fire <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdc(OFF_CON1, 16'h0000, "con1 reset");
    rdc(OFF_CON2, 16'h000c, "con2 reset");
    wr(5'h18, 16'hffff);
    rdc(5'h18, 16'h0000, "unmapped");
    wr(OFF_CNT, 16'h1234);
    rdc(OFF_CNT, 16'h0000, "counter while off");
    wr(OFF_CON1, 16'hffff);
    rdc(OFF_CON1, 16'h3fff, "con1 mask");
    wr(OFF_CON2, 16'h0000);
    wr(OFF_PRI, 16'h0004);
    wr(OFF_SEC, 16'h0008);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_CON1, 16'h0000);
      wr(OFF_CON1, 16'h1c00 | 16'(i + 1));
      base = irq_cnt;
      repeat (8) @(posedge clk);
      e[0] = pin;
      repeat (18) @(posedge clk);
      e[1] = pin;
      repeat (24) @(posedge clk);
      e[2] = pin;
      chk(16'(e), 16'(EXP_LV[i]), "compare levels");
      chk(16'(irq_cnt - base), 16'h0001, "match interrupt");
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CON1, 16'h0000);
      wr(OFF_CON1, {3'h0, CLK_TAB[i], 10'h001});
      bus(1'b0, OFF_CNT, 16'h0000, rv);
      repeat (60) @(posedge clk);
      bus(1'b0, OFF_CNT, 16'h0000, rv2);
      d = $isunknown({rv, rv2}) ? -100 : int'(rv2 - rv);
      chk(16'(d >= EXP_TK[i] - 2 && d <= EXP_TK[i] + 2), 16'h0001, "tick rate");
    end
    wr(OFF_CON1, 16'h0000);
    wr(OFF_CON2, 16'h008b);
    wr(OFF_CON1, 16'h1c01);
    rdc(OFF_CNT, 16'h0000, "held before trigger");
    fire(5'h0b);
    repeat (20) @(posedge clk);
    rdc(OFF_CON2, 16'h00cb, "trigger status set");
    bus(1'b0, OFF_CNT, 16'h0000, rv);
    chk(16'(rv > 16'h0002), 16'h0001, "running after trigger");
    wr(OFF_CON2, 16'h008b);
    rdc(OFF_CNT, 16'h0000, "software clear");
    wr(OFF_SEC, 16'h0003);
    wr(OFF_CON1, 16'h1c09);
    fire(5'h0b);
    repeat (40) @(posedge clk);
    rdc(OFF_CON2, 16'h008b, "cleared on secondary");
    rdc(OFF_CNT, 16'h0000, "held after clear");
    wr(OFF_CON2, 16'h000b);
    repeat (100) @(posedge clk);
    bus(1'b0, OFF_CNT, 16'h0000, rv);
    chk(16'(rv > 16'h0010), 16'h0001, "sync mode runs");
    fire(5'h0b);
    bus(1'b0, OFF_CNT, 16'h0000, rv);
    chk(16'(rv < 16'h0002), 16'h0001, "sync event resets");
    wr(OFF_CON1, 16'h0000);
    wr(OFF_CON2, 16'h001f);
    wr(OFF_PER, 16'h0007);
    wr(OFF_PRI, 16'h0000);
    wr(OFF_CON1, 16'h1c06);
    pulse();
    pulse();
    chk(16'(pd), 16'h0020, "pwm period");
    chk(16'(hi), 16'h000c, "pwm duty");
    t_rise = cyc;
    wr(OFF_SEC, 16'h0005);
    lvl(1'b0);
    chk(16'(cyc - t_rise), 16'h000c, "duty held mid period");
    pulse();
    pulse();
    chk(16'(hi), 16'h0014, "new duty latched");
    wr(OFF_PRI, 16'h0002);
    wr(OFF_CON1, 16'h1c07);
    pulse();
    pulse();
    chk(16'(hi), 16'h000c, "center duty");
    wr(OFF_CON1, 16'h1c06);
    wr(OFF_CON2, 16'h041f);
    pulse();
    pulse();
    chk(16'(hi), 16'h0016, "fine delay");
    wr(OFF_CON2, 16'h101f);
    wr(OFF_PER, 16'h0000);
    wr(OFF_SEC, 16'h0000);
    // restart pwm so the counter meets the new zero period at once
    wr(OFF_CON1, 16'h0000);
    wr(OFF_CON1, 16'h1c06);
    repeat (40) @(posedge clk);
    steady(1'b1, "inverted zero duty");
    wr(OFF_CON2, 16'h001f);
    repeat (8) @(posedge clk);
    steady(1'b0, "zero duty");
    wr(OFF_PER, 16'h0007);
    wr(OFF_SEC, 16'h0009);
    repeat (80) @(posedge clk);
    steady(1'b1, "full duty");
    base = sync_cnt;
    repeat (64) @(posedge clk);
    chk(16'(sync_cnt - base), 16'h0002, "sync out per period");
    wr(OFF_SEC, 16'h0003);
    wr(OFF_CON2, 16'h203f);
    wr(OFF_CON1, 16'h1f86);
    repeat (4) @(posedge clk);
    chk(16'(oe), 16'h0000, "pin released");
    fault_req <= 3'h7;
    repeat (20) @(posedge clk);
    chk(16'(oe), 16'h0001, "fault drives pin");
    steady(1'b0, "fault level");
    rdc(OFF_CON1, 16'h1ff6, "fault flags");
    fault_req <= 3'h0;
    repeat (10) @(posedge clk);
    wr(OFF_CON1, 16'h1f86);
    rdc(OFF_CON1, 16'h1f86, "flags cleared");
    wr(OFF_CON1, 16'h1f81);
    fault_req <= 3'h7;
    repeat (20) @(posedge clk);
    rdc(OFF_CON1, 16'h1f81, "no flags outside pwm");
    chk(16'(oe), 16'h0000, "no fault outside pwm");
    fault_req <= 3'h0;
    wrap_up();
  end
endmodule
`default_nettype wire

// *** verilog/ocp_pkg.sv ***
// package: register map, fields, codes and state type of the compare/pwm channel
package ocp_pkg;

  // register byte offsets on the avalon slave
  localparam logic [4:0] OFF_CON1 = 5'h00;
  localparam logic [4:0] OFF_CON2 = 5'h04;
  localparam logic [4:0] OFF_PRI = 5'h08;
  localparam logic [4:0] OFF_SEC = 5'h0c;
  localparam logic [4:0] OFF_PER = 5'h10;
  localparam logic [4:0] OFF_CNT = 5'h14;

  // compare_control_one fields
  localparam int CON1_CLKSEL_LSB = 10;
  localparam int CON1_ENFLT_LSB = 7;
  localparam int CON1_FLAG_LSB = 4;
  localparam int CON1_TRIGGER_CLEAR_POLICY_BIT = 3;
  localparam int CON1_MODE_LSB = 0;

  // compare_control_two fields
  localparam int CON2_FLTTRI_BIT = 13;
  localparam int CON2_INV_BIT = 12;
  localparam int CON2_DCB_LSB = 9;
  localparam int CON2_TRIG_BIT = 7;
  localparam int CON2_TRIGGER_STATUS_BIT = 6;
  localparam int CON2_TRIS_BIT = 5;
  localparam int CON2_SYNC_LSB = 0;

  localparam logic [15:0] CON1_RESET = 16'h0000;
  localparam logic [15:0] CON2_RESET = 16'h000c;
  localparam logic [15:0] CON1_WMASK = 16'h3fff;
  localparam logic [15:0] CON2_WMASK = 16'hf7ff;

  // compare_mode_select codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SS_HIGH = 3'h1;
  localparam logic [2:0] MODE_SS_LOW = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_DBL_ONE = 3'h4;
  localparam logic [2:0] MODE_DBL_CONT = 3'h5;
  localparam logic [2:0] MODE_EDGE = 3'h6;
  localparam logic [2:0] MODE_CENTER = 3'h7;

  // clock_source_select codes
  localparam logic [2:0] CLK_PERIPH = 3'h7;
  localparam logic [2:0] CLK_TMR1 = 3'h4;
  localparam logic [2:0] CLK_TMR3 = 3'h1;

  // sync_source_select codes
  localparam logic [4:0] SYNC_OFF = 5'h00;
  localparam logic [4:0] SYNC_SELF = 5'h1f;

  // clk cycles per instruction cycle
  localparam int INSTR_DIV_DEFAULT = 4;

  typedef struct packed {
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] pri;
    logic [15:0] sec;
    logic [15:0] per;
    logic [15:0] cnt;
    logic [15:0] pri_sh;
    logic [15:0] sec_sh;
    logic [1:0] dcb_sh;
    logic wave;
    logic done;
    logic pwm_q;
    logic prev_raw;
    logic pin;
    logic oe;
    logic irq;
    logic sync_o;
    logic ack;
    logic [7:0] dly;
    logic [7:0] div;
    logic [2:0] fa_sync;
    logic [2:0] fb_sync;
    logic fa_lvl;
    logic fb_lvl;
    logic [31:0] rdata;
  } ocp_state_t;

  localparam ocp_state_t OCP_STATE_RESET = '{con1: CON1_RESET, con2: CON2_RESET, default: '0};

  function automatic logic ocp_is_pwm(input logic [2:0] mode);
    return (mode == MODE_EDGE) || (mode == MODE_CENTER);
  endfunction

endpackage

// *** verilog/ocp_unit.sv ***
// output compare / pwm channel with avalon-mm register slave
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - pwm modes use internal shadow copies of compare values, not bus registers
// - pwm period lasts period value plus one time base counts
// - compare writes accepted anytime, shadows loaded at count equals period or on entering pwm
// - all compare and period values zero keeps pin low
// - secondary compare above period keeps pin high
// - clock code 111 peripheral, 100 first timer, 001 third timer, others stop
// - timer sources use that timer's prescaler tick
// - each fault source sets its own flag; software may write flags
// - fault enables and flags act only in pwm modes
// - fault tristate control forces pin driven during fault
// - invert control inverts the generated waveform on the pin
// - fine delay postpones falling edge by quarters of an instruction cycle
// - fine delay buffered in pwm modes, direct otherwise
// - one bit selects trigger or synchronous operation
// - clear policy also clears trigger status on counter equal secondary
// - double compare starts low; 101 continuous, 100 one pulse
// - 011 toggles, 010 starts high then low, 001 starts low then high
// - 111 center pwm, 110 edge pwm, 000 channel off
// - sync code 00000 free running; field resets to 01100
// - trigger mode waits for event; sync mode resets counter on event
// - free running counter wraps from ffff to zero
// - interrupt flag on primary match single, secondary match double
module ocp_unit
  import ocp_pkg::*;
#(
  parameter int INSTR_DIV = INSTR_DIV_DEFAULT,
  parameter logic FAULT_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer1_prescale_tick,
  input wire logic timer3_prescale_tick,
  input wire logic [31:0] sync_events,
  input wire logic comparator_fault,
  input wire logic fault_pin_a,
  input wire logic fault_pin_b,
  output logic compare_output_pin,
  output logic compare_output_oe,
  output logic channel_interrupt_flag,
  output logic sync_out
);

  if (INSTR_DIV < 4 || INSTR_DIV > 256 || (INSTR_DIV % 4) != 0) begin : g_bad_div
    $error("INSTR_DIV must be a multiple of 4 from 4 to 256");
  end

  localparam logic [7:0] DIV_LAST = 8'(INSTR_DIV - 1);
  localparam logic [7:0] QUARTER = 8'(INSTR_DIV / 4);

  ocp_state_t s;
  ocp_state_t next_s;

  logic [2:0] mode;
  logic [2:0] clk_sel;
  logic [2:0] enflt;
  logic [2:0] flags;
  logic [4:0] sync_sel;
  logic [1:0] dcb;
  logic pwm;
  logic trig;
  logic trigger_status;
  logic trigger_clear_policy;
  logic inv;
  logic tick;
  logic per_hit;
  logic ev;
  logic running;
  logic mp;
  logic ms;
  logic pwm_wave;
  logic raw;
  logic fall;
  logic shaped;
  logic fault_act;
  logic req;
  logic wr;
  logic con1_w;
  logic con2_w;
  logic [15:0] base1;
  logic [15:0] base2;
  logic [2:0] flag_set;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  assign mode = s.con1[CON1_MODE_LSB +: 3];
  assign clk_sel = s.con1[CON1_CLKSEL_LSB +: 3];
  assign enflt = s.con1[CON1_ENFLT_LSB +: 3];
  assign flags = s.con1[CON1_FLAG_LSB +: 3];
  assign trigger_clear_policy = s.con1[CON1_TRIGGER_CLEAR_POLICY_BIT];
  assign sync_sel = s.con2[CON2_SYNC_LSB +: 5];
  assign trig = s.con2[CON2_TRIG_BIT];
  assign trigger_status = s.con2[CON2_TRIGGER_STATUS_BIT];
  assign inv = s.con2[CON2_INV_BIT];
  assign pwm = ocp_is_pwm(mode);
  assign dcb = pwm ? s.dcb_sh : s.con2[CON2_DCB_LSB +: 2];

  // time base tick from the chosen source
  assign tick = (clk_sel == CLK_PERIPH) ? (s.div == DIV_LAST) :
                (clk_sel == CLK_TMR1) ? timer1_prescale_tick :
                (clk_sel == CLK_TMR3) ? timer3_prescale_tick : 1'b0;
  assign per_hit = tick && (s.cnt == s.per);
  assign ev = (sync_sel == SYNC_OFF) ? 1'b0 :
              (sync_sel == SYNC_SELF) ? per_hit : sync_events[sync_sel];
  assign running = (mode != MODE_OFF) && !(trig && !trigger_status);
  assign mp = tick && (s.cnt == s.pri);
  assign ms = tick && (s.cnt == s.sec);

  // pwm waveform from shadow copies
  always_comb begin
    if (s.sec_sh > s.per) begin
      pwm_wave = 1'b1;
    end else if (mode == MODE_CENTER) begin
      pwm_wave = (s.cnt >= s.pri_sh) && (s.cnt < s.sec_sh);
    end else begin
      pwm_wave = s.cnt < s.sec_sh;
    end
  end

  assign raw = pwm ? pwm_wave : s.wave;
  assign fall = s.prev_raw && !raw;
  assign shaped = raw || (s.dly != 8'h00) || (fall && dcb != 2'b00);
  assign fault_act = pwm && (flags != 3'b000);
  assign flag_set = pwm ? (enflt & {comparator_fault, s.fb_lvl, s.fa_lvl}) : 3'b000;

  assign req = avs_read || avs_write;
  assign wr = s.ack && avs_write;
  assign con1_w = wr && (avs_address == OFF_CON1);
  assign con2_w = wr && (avs_address == OFF_CON2);
  assign base1 = con1_w ? (merge16(s.con1, avs_writedata, avs_byteenable) & CON1_WMASK) : s.con1;
  assign base2 = con2_w ? (merge16(s.con2, avs_writedata, avs_byteenable) & CON2_WMASK) : s.con2;

  always_comb begin
    next_s = s;
    // bus slave: one wait cycle, then answer
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      unique case (avs_address)
        OFF_CON1: next_s.rdata = {16'h0000, s.con1};
        OFF_CON2: next_s.rdata = {16'h0000, s.con2};
        OFF_PRI: next_s.rdata = {16'h0000, s.pri};
        OFF_SEC: next_s.rdata = {16'h0000, s.sec};
        OFF_PER: next_s.rdata = {16'h0000, s.per};
        OFF_CNT: next_s.rdata = {16'h0000, s.cnt};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (wr && avs_address == OFF_PRI) begin
      next_s.pri = merge16(s.pri, avs_writedata, avs_byteenable);
    end
    if (wr && avs_address == OFF_SEC) begin
      next_s.sec = merge16(s.sec, avs_writedata, avs_byteenable);
    end
    if (wr && avs_address == OFF_PER) begin
      next_s.per = merge16(s.per, avs_writedata, avs_byteenable);
    end
    // fault flags: hardware set wins over software write
    next_s.con1 = base1;
    next_s.con1[CON1_FLAG_LSB +: 3] = base1[CON1_FLAG_LSB +: 3] | flag_set;
    next_s.con2 = base2;
    if (trig && ev) begin
      next_s.con2[CON2_TRIGGER_STATUS_BIT] = 1'b1;
    end else if (trigger_clear_policy && ms && !con2_w) begin
      next_s.con2[CON2_TRIGGER_STATUS_BIT] = 1'b0;
    end
    // peripheral clock divider
    next_s.div = (s.div == DIV_LAST) ? 8'h00 : s.div + 8'h01;
    // internal counter
    if (!running) begin
      next_s.cnt = 16'h0000;
    end else if (!trig && ev) begin
      next_s.cnt = 16'h0000;
    end else if (tick) begin
      if (pwm && s.cnt == s.per) begin
        next_s.cnt = 16'h0000;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end
    // shadow loads at period end or on entering pwm
    next_s.pwm_q = pwm;
    if (pwm && (per_hit || !s.pwm_q)) begin
      next_s.pri_sh = s.pri;
      next_s.sec_sh = s.sec;
      next_s.dcb_sh = s.con2[CON2_DCB_LSB +: 2];
    end
    // compare mode waveform
    if (con1_w) begin
      next_s.wave = (base1[CON1_MODE_LSB +: 3] == MODE_SS_LOW);
      next_s.done = 1'b0;
    end else begin
      unique case (mode)
        MODE_OFF: next_s.wave = 1'b0;
        MODE_SS_HIGH: begin
          if (mp && !s.done) begin
            next_s.wave = 1'b1;
            next_s.done = 1'b1;
          end
        end
        MODE_SS_LOW: begin
          if (mp && !s.done) begin
            next_s.wave = 1'b0;
            next_s.done = 1'b1;
          end
        end
        MODE_TOGGLE: begin
          if (mp) begin
            next_s.wave = !s.wave;
          end
        end
        MODE_DBL_ONE: begin
          if (!s.done && ms) begin
            next_s.wave = 1'b0;
            next_s.done = 1'b1;
          end else if (!s.done && mp) begin
            next_s.wave = 1'b1;
          end
        end
        MODE_DBL_CONT: begin
          if (ms) begin
            next_s.wave = 1'b0;
          end else if (mp) begin
            next_s.wave = 1'b1;
          end
        end
        MODE_EDGE, MODE_CENTER: next_s.wave = 1'b0;
      endcase
    end
    // interrupt event pulse
    if (mode == MODE_SS_HIGH || mode == MODE_SS_LOW || mode == MODE_TOGGLE) begin
      next_s.irq = mp;
    end else if (mode == MODE_DBL_ONE || mode == MODE_DBL_CONT) begin
      next_s.irq = ms;
    end else begin
      next_s.irq = pwm && per_hit;
    end
    next_s.sync_o = per_hit;
    // falling edge fine delay
    next_s.prev_raw = raw;
    if (raw) begin
      next_s.dly = 8'h00;
    end else if (fall && dcb != 2'b00) begin
      next_s.dly = QUARTER * {6'h00, dcb} - 8'h01;
    end else if (s.dly != 8'h00) begin
      next_s.dly = s.dly - 8'h01;
    end
    // pin level and direction
    next_s.pin = fault_act ? FAULT_LEVEL : (shaped ^ inv);
    next_s.oe = !s.con2[CON2_TRIS_BIT] || (fault_act && s.con2[CON2_FLTTRI_BIT]);
    // fault pin synchronisers: change taken once stages 2 and 3 agree
    next_s.fa_sync = {s.fa_sync[1:0], fault_pin_a};
    next_s.fb_sync = {s.fb_sync[1:0], fault_pin_b};
    if (s.fa_sync[1] == s.fa_sync[2]) begin
      next_s.fa_lvl = s.fa_sync[2];
    end
    if (s.fb_sync[1] == s.fb_sync[2]) begin
      next_s.fb_lvl = s.fb_sync[2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= OCP_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest = req && !s.ack;
  assign avs_readdata = s.rdata;
  assign compare_output_pin = s.pin;
  assign compare_output_oe = s.oe;
  assign channel_interrupt_flag = s.irq;
  assign sync_out = s.sync_o;

  a_period_wrap: assert property (@(posedge clk) disable iff (srst)
    running && pwm && per_hit && !(!trig && ev) |=> s.cnt == 16'h0000)
    else $error("pwm counter did not wrap at period");

  a_shadow_load: assert property (@(posedge clk) disable iff (srst)
    pwm && s.pwm_q && per_hit |=> s.sec_sh == $past(s.sec) && s.pri_sh == $past(s.pri))
    else $error("shadow not loaded at period match");

  a_shadow_hold: assert property (@(posedge clk) disable iff (srst)
    pwm && s.pwm_q && !per_hit |=> $stable(s.sec_sh))
    else $error("shadow changed mid period");

  a_zero_duty: assert property (@(posedge clk) disable iff (srst)
    pwm && s.sec_sh == 16'h0000 && s.pri_sh == 16'h0000 && s.per == 16'h0000 |-> !pwm_wave)
    else $error("zero duty not low");

  a_full_duty: assert property (@(posedge clk) disable iff (srst)
    pwm && s.sec_sh > s.per && !fault_act && !inv |=> compare_output_pin)
    else $error("full duty not high");

  a_invert_pin: assert property (@(posedge clk) disable iff (srst)
    !fault_act |=> compare_output_pin == ($past(shaped) ^ $past(inv)))
    else $error("pin does not follow waveform and invert");

  a_fault_flag: assert property (@(posedge clk) disable iff (srst)
    pwm && enflt[0] && s.fa_lvl |=> s.con1[CON1_FLAG_LSB])
    else $error("pin a fault flag not set");

  a_fault_drive: assert property (@(posedge clk) disable iff (srst)
    fault_act && s.con2[CON2_FLTTRI_BIT] |=> compare_output_oe && compare_output_pin == FAULT_LEVEL)
    else $error("pin not driven during fault");

  a_trig_clear: assert property (@(posedge clk) disable iff (srst)
    trigger_clear_policy && ms && !con2_w && !(trig && ev) |=> !trigger_status)
    else $error("trigger status not cleared on secondary match");

  a_trig_wait: assert property (@(posedge clk) disable iff (srst)
    trig && !trigger_status ##1 trig && !trigger_status |-> s.cnt == 16'h0000)
    else $error("counter ran before trigger");

  a_free_wrap: assert property (@(posedge clk) disable iff (srst)
    running && !pwm && sync_sel == SYNC_OFF && tick |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("free running counter did not step or wrap");

  a_single_high: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_SS_HIGH && mp && !con1_w |=> s.wave ##1 ($past(con1_w) || s.wave))
    else $error("single shot high did not hold");

  a_irq_double: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_DBL_CONT && ms |=> channel_interrupt_flag)
    else $error("interrupt flag missing on secondary match");

  a_fine_delay: assert property (@(posedge clk) disable iff (srst)
    dcb != 2'b00 && fall && !fault_act && !inv
      |=> compare_output_pin)
    else $error("falling edge not delayed");

endmodule

`default_nettype wire
